// ### core/wdri_regs.svh
// Purpose: register indices, field positions, reset values and timing counts
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef WDRI_REGS_SVH
`define WDRI_REGS_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define WDRI_IDX_RUN_CONTROL 10'h000
`define WDRI_IDX_PERIOD_CONFIG 10'h001
`define WDRI_IDX_EARLY_WARNING_CONTROL 10'h002
`define WDRI_IDX_INTERRUPT_ENABLE_CLEAR 10'h004
`define WDRI_IDX_INTERRUPT_ENABLE_SET 10'h005
`define WDRI_IDX_INTERRUPT_FLAGS 10'h006
`define WDRI_IDX_SYNC_STATUS 10'h007
`define WDRI_IDX_SERVICE_KEY 10'h008

// ****************************************************************
// field positions
// ****************************************************************
`define WDRI_BIT_ENABLE 1
`define WDRI_BIT_WINDOW 2
`define WDRI_BIT_LOCK 7
`define WDRI_LSB_PERIOD 0
`define WDRI_LSB_CLOSED 4
`define WDRI_LSB_EW_OFFSET 0
`define WDRI_BIT_EARLY_WARNING 0
`define WDRI_BIT_SYNC_BUSY 7

// ****************************************************************
// values and timing
// ****************************************************************
`define WDRI_RESET_BYTE 8'h00
`define WDRI_SERVICE_KEY_VALUE 8'hA5
`define WDRI_CODE_MAX 4'hB
`define WDRI_BASE_LEN 16'h0008
`define WDRI_PCLK_NS 40
`define WDRI_COUNT_CLK_NS 1000
`define WDRI_TICK_CYCLES ((`WDRI_COUNT_CLK_NS) / (`WDRI_PCLK_NS))

`endif

// ### core/wdri_pkg.sv
// Purpose: types shared by the watchdog register interface
// Assumes: constants come from wdri_regs.svh
// Notes: period codes above the top code act as the top code
package wdri_pkg;
	`include "wdri_regs.svh"

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} wdri_apb_req_t;

	typedef struct packed {
		logic permanent_run_lock;
		logic window_mode;
		logic enable;
		logic [3:0] closed_window_code;
		logic [3:0] timeout_period_code;
		logic [3:0] early_warning_offset_code;
	} wdri_cfg_t;

	typedef enum logic [1:0] {
		WDRI_OFF,
		WDRI_CLOSED,
		WDRI_OPEN
	} wdri_state_t;

	// power-of-two length in count clock cycles, 8 .. 16384
	function automatic logic [14:0] wdri_len(input logic [3:0] code);
		logic [3:0] c;
		logic [15:0] v;
		c = (code > `WDRI_CODE_MAX) ? `WDRI_CODE_MAX : code;
		v = `WDRI_BASE_LEN << c;
		return v[14:0];
	endfunction : wdri_len
endpackage : wdri_pkg

// ### core/wdri_tick.sv
// Purpose: count clock enable, one pclk pulse per count clock period
// Assumes: single pclk domain
// Notes: stands in for the separate watchdog clock
`timescale 1ns/10ps
module wdri_tick #(
	parameter int DIV = 25
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// enable out
	output logic tick
);
	import wdri_pkg::*;

	logic [15:0] cnt;

	initial begin
		if (DIV < 2 || DIV > 65535) begin
			$error("wdri_tick: DIV out of range");
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt == 16'(DIV - 1)) begin
			cnt <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule : wdri_tick

// ### core/wdri_top.sv
// Purpose: watchdog with period, early warning, keyed service and APB regs
// Assumes: APB3 slave, 32-bit data, byte address = index * 4
// Notes: count clock is an enable from wdri_tick; sync ends at its tick
//
// What this block does
// [RULE1] period code sets time-out, 8 to 16384
// [RULE2] window mode: period code is open window
// [RULE3] offset code sets early warning point
// [RULE4] period and offset loaded from user row
// [RULE5] unused bits read zero, software writes zero
// [RULE6] enable-clear one disables early warning
// [RULE7] enable-set one enables early warning
// [RULE8] both enable registers read one shared state
// [RULE9] flag set at early warning point
// [RULE10] writing one clears the flag
// [RULE11] busy bit tracks cross-domain register sync
// [RULE12] key write restarts the period
// [RULE13] wrong key value resets the system
// [RULE14] window mode warns at open window start
// [RULE15] sync register write while busy stalls the bus
// [RULE16] closed window code, same power-of-two lengths
// [RULE17] lock bit freezes control, config, warning control
// [RULE18] period end without service resets system
// [RULE19] irq when flag and enable both set
// [RULE20] key in closed window resets system
`timescale 1ns/10ps
`include "wdri_regs.svh"
module wdri_top #(
	parameter int TICK_DIV = `WDRI_TICK_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire wdri_pkg::wdri_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// user row values taken after reset
	input wire wdri_pkg::wdri_cfg_t user_row_cfg,
	// system side
	output logic irq,
	output logic wdt_sys_reset
);
	import wdri_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	wdri_cfg_t cfg;
	wdri_cfg_t act;
	wdri_state_t state;
	logic loaded;
	logic tick;
	logic sync_pend;
	logic key_pend;
	logic busy;
	logic inten;
	logic ew_flag;
	logic [14:0] cnt;
	logic [9:0] idx;
	logic [7:0] wbyte;
	logic mapped;
	logic sync_reg;
	logic stall;
	logic acc;
	logic wr;
	logic wr_ok;
	logic key_ok;
	logic bad_key;
	logic ew_evt;
	logic timeout_evt;
	logic [14:0] next_cnt;
	logic [7:0] rbyte;
	assign busy = sync_pend | key_pend;
	assign idx = apb_req.paddr[11:2];
	assign wbyte = apb_req.pwdata[7:0];
	assign mapped = (idx <= `WDRI_IDX_SERVICE_KEY) && (idx != 10'h003);
	assign sync_reg = (idx == `WDRI_IDX_RUN_CONTROL) ||
		(idx == `WDRI_IDX_PERIOD_CONFIG) ||
		(idx == `WDRI_IDX_EARLY_WARNING_CONTROL) ||
		(idx == `WDRI_IDX_SERVICE_KEY);
	// a sync write waits for the previous sync to finish
	assign stall = apb_req.pwrite && sync_reg && mapped && busy; // [RULE15]
	assign acc = apb_req.psel && apb_req.penable && !pready && !stall;
	assign wr = pready && apb_req.psel && apb_req.penable &&
		apb_req.pwrite && mapped && loaded;
	// lock freezes the three configuration registers
	assign wr_ok = wr && !cfg.permanent_run_lock; // [RULE17]
	assign key_ok = wbyte == `WDRI_SERVICE_KEY_VALUE;
	// wrong key, or any key while the closed window runs, resets at once
	assign bad_key = wr && (idx == `WDRI_IDX_SERVICE_KEY) &&
		(!key_ok || state == WDRI_CLOSED); // [RULE13] [RULE20]
	assign next_cnt = cnt + 15'h0001;

	// ****************************************************************
	// count clock enable
	// ****************************************************************
	wdri_tick #(
		.DIV(TICK_DIV)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick)
	);
	initial begin
		if (TICK_DIV < 2) begin
			$error("wdri_top: TICK_DIV must be at least 2");
		end
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= '0;
			loaded <= 1'b0;
		end else if (!loaded) begin
			// user row values are caught once, after reset release
			cfg <= user_row_cfg; // [RULE4]
			loaded <= 1'b1;
		end else if (wr_ok) begin
			case (idx)
				`WDRI_IDX_RUN_CONTROL: begin
					cfg.enable <= wbyte[`WDRI_BIT_ENABLE];
					if (!cfg.enable) begin
						cfg.window_mode <= wbyte[`WDRI_BIT_WINDOW];
					end
					// only a power-on reset drops the lock
					if (wbyte[`WDRI_BIT_LOCK]) begin
						cfg.permanent_run_lock <= 1'b1; // [RULE17]
					end
				end
				`WDRI_IDX_PERIOD_CONFIG: begin
					cfg.timeout_period_code <=
						wbyte[`WDRI_LSB_PERIOD +: 4]; // [RULE1]
					cfg.closed_window_code <=
						wbyte[`WDRI_LSB_CLOSED +: 4]; // [RULE16]
				end
				`WDRI_IDX_EARLY_WARNING_CONTROL: begin
					cfg.early_warning_offset_code <=
						wbyte[`WDRI_LSB_EW_OFFSET +: 4]; // [RULE3]
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// synchronisation to the count clock
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_pend <= 1'b0;
		end else if (wr_ok && sync_reg && idx != `WDRI_IDX_SERVICE_KEY) begin
			sync_pend <= 1'b1; // [RULE11]
		end else if (tick) begin
			sync_pend <= 1'b0; // [RULE11]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_pend <= 1'b0;
		end else if (wr && idx == `WDRI_IDX_SERVICE_KEY && !bad_key) begin
			key_pend <= 1'b1; // [RULE11]
		end else if (tick) begin
			key_pend <= 1'b0;
		end
	end

	// the counting side sees the user row at load, then only the copy taken at a tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act <= '0;
		end else if (tick && sync_pend) begin
			act <= cfg;
		end else if (!loaded) begin
			act <= user_row_cfg; // [RULE4]
		end
	end

	// ****************************************************************
	// watchdog counter
	// ****************************************************************
	always_comb begin
		ew_evt = 1'b0;
		timeout_evt = 1'b0;
		if (tick && act.enable && !(key_pend)) begin
			case (state)
				WDRI_CLOSED: begin
					// warning marks the open window start
					ew_evt = next_cnt == wdri_len(act.closed_window_code); // [RULE14]
				end
				WDRI_OPEN: begin
					ew_evt = !act.window_mode && next_cnt ==
						wdri_len(act.early_warning_offset_code); // [RULE9]
					timeout_evt = next_cnt ==
						wdri_len(act.timeout_period_code); // [RULE18]
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= WDRI_OFF;
			cnt <= 15'h0000;
		end else if (bad_key) begin
			state <= WDRI_OFF;
			cnt <= 15'h0000;
		end else if (tick) begin
			if (!act.enable) begin
				state <= WDRI_OFF;
				cnt <= 15'h0000;
			end else if (key_pend || timeout_evt || state == WDRI_OFF) begin
				// service restarts the full period
				state <= act.window_mode ? WDRI_CLOSED : WDRI_OPEN; // [RULE12]
				cnt <= 15'h0000;
			end else if (state == WDRI_CLOSED && ew_evt) begin
				// open window length follows the period code
				state <= WDRI_OPEN; // [RULE2]
				cnt <= 15'h0000;
			end else begin
				cnt <= next_cnt;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_sys_reset <= 1'b0;
		end else begin
			wdt_sys_reset <= bad_key || timeout_evt; // [RULE13] [RULE18]
		end
	end

	// ****************************************************************
	// interrupt enable, flag and request
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inten <= 1'b0;
		end else if (wr && idx == `WDRI_IDX_INTERRUPT_ENABLE_SET &&
			wbyte[`WDRI_BIT_EARLY_WARNING]) begin
			inten <= 1'b1; // [RULE7]
		end else if (wr && idx == `WDRI_IDX_INTERRUPT_ENABLE_CLEAR &&
			wbyte[`WDRI_BIT_EARLY_WARNING]) begin
			inten <= 1'b0; // [RULE6]
		end
	end

	// a warning in the same cycle as the clear is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ew_flag <= 1'b0;
		end else if (ew_evt) begin
			ew_flag <= 1'b1; // [RULE9]
		end else if (wr && idx == `WDRI_IDX_INTERRUPT_FLAGS &&
			wbyte[`WDRI_BIT_EARLY_WARNING]) begin
			ew_flag <= 1'b0; // [RULE10]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= ew_flag && inten; // [RULE19]
		end
	end
	// ****************************************************************
	// apb answer
	// ****************************************************************
	always_comb begin
		rbyte = `WDRI_RESET_BYTE;
		case (idx)
			`WDRI_IDX_RUN_CONTROL: begin
				rbyte[`WDRI_BIT_ENABLE] = cfg.enable;
				rbyte[`WDRI_BIT_WINDOW] = cfg.window_mode;
				rbyte[`WDRI_BIT_LOCK] = cfg.permanent_run_lock;
			end
			`WDRI_IDX_PERIOD_CONFIG: begin
				rbyte[`WDRI_LSB_PERIOD +: 4] = cfg.timeout_period_code;
				rbyte[`WDRI_LSB_CLOSED +: 4] = cfg.closed_window_code;
			end
			`WDRI_IDX_EARLY_WARNING_CONTROL: begin
				rbyte[`WDRI_LSB_EW_OFFSET +: 4] =
					cfg.early_warning_offset_code;
			end
			`WDRI_IDX_INTERRUPT_ENABLE_CLEAR,
			`WDRI_IDX_INTERRUPT_ENABLE_SET: begin
				rbyte[`WDRI_BIT_EARLY_WARNING] = inten; // [RULE8]
			end
			`WDRI_IDX_INTERRUPT_FLAGS: begin
				rbyte[`WDRI_BIT_EARLY_WARNING] = ew_flag;
			end
			`WDRI_IDX_SYNC_STATUS: begin
				rbyte[`WDRI_BIT_SYNC_BUSY] = busy; // [RULE11]
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (acc) begin
			pready <= 1'b1;
			pslverr <= !mapped;
			// reserved bits and the write-only key read as zero
			prdata <= {24'h000000, apb_req.pwrite ? 8'h00 : rbyte}; // [RULE5]
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_irq_from_flag: assert property ( // [RULE19]
		ew_flag && inten |=> irq)
		else $error("irq missing with flag and enable set");
	a_enable_clear: assert property ( // [RULE6]
		wr && idx == `WDRI_IDX_INTERRUPT_ENABLE_CLEAR &&
		wbyte[0] |=> !inten ##1 (!pready && !irq))
		else $error("enable clear did not disable");
	a_enable_set: assert property ( // [RULE7]
		wr && idx == `WDRI_IDX_INTERRUPT_ENABLE_SET && wbyte[0] |=> inten)
		else $error("enable set did not enable");
	a_flag_clear: assert property ( // [RULE10]
		wr && idx == `WDRI_IDX_INTERRUPT_FLAGS && wbyte[0] && !ew_evt
		|=> !ew_flag)
		else $error("flag not cleared");
	a_busy_on_sync: assert property ( // [RULE11]
		wr_ok && sync_reg && !tick && !bad_key |=> busy)
		else $error("busy not set on sync write");
	a_stall_while_busy: assert property ( // [RULE15]
		apb_req.psel && apb_req.penable && stall |=> !pready)
		else $error("sync access not stalled");
	a_bad_key_reset: assert property ( // [RULE13]
		wr && idx == `WDRI_IDX_SERVICE_KEY && !key_ok |=> wdt_sys_reset)
		else $error("wrong key gave no reset");
	a_timeout_reset: assert property ( // [RULE18]
		timeout_evt |=> wdt_sys_reset && cnt == 15'h0000)
		else $error("timeout gave no reset");
	a_key_restart: assert property ( // [RULE12]
		tick && key_pend && act.enable |=> cnt == 15'h0000 && !key_pend)
		else $error("key did not restart count");
	a_lock_freezes: assert property ( // [RULE17]
		loaded && cfg.permanent_run_lock |=> $stable(cfg))
		else $error("locked configuration changed");
	c_timeout: cover property (timeout_evt);
	c_ew_irq: cover property (ew_evt ##[1:40] irq);
	c_stall: cover property (stall && apb_req.penable);
	c_window_key: cover property (bad_key && key_ok);
endmodule : wdri_top

// ### verification/wdri_top_tb.sv
// Purpose: self-checking bench for the watchdog register interface
// Assumes: TICK_DIV shortened to 16 pclk cycles per count tick
// Notes: event delays are measured against a free cycle counter
`timescale 1ns/10ps
module wdri_top_tb;
	import wdri_pkg::*;
	localparam int D = 16;
	localparam int LIMIT = 10000;
	logic pclk;
	logic presetn;
	wdri_apb_req_t req;
	wdri_cfg_t cfg;
	logic [31:0] prdata;
	logic pready, pslverr, irq, wdt_sys_reset, irq_q, re;
	logic [31:0] rv;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int rst_cnt = 0;
	int rst_cyc = 0;
	int irq_cyc = -1;
	int t0, n;

	wdri_top #(.TICK_DIV(D)) wdri_top_inst (
		.pclk(pclk),
		.presetn(presetn),
		.apb_req(req),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.user_row_cfg(cfg),
		.irq(irq),
		.wdt_sys_reset(wdt_sys_reset)
	);

	// ****************************************************************
	// clock, event monitor, timeout
	// ****************************************************************
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// delays are judged from these stamps, never from design internals
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		irq_q <= irq;
		if (wdt_sys_reset === 1'b1) begin
			rst_cnt <= rst_cnt + 1;
			rst_cyc <= cyc;
		end
		if (irq === 1'b1 && irq_q !== 1'b1) begin
			irq_cyc <= cyc;
		end
		if (cyc == LIMIT) begin
			err_count++;
			stop_test();
		end
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic stop_test();
		if (err_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic rng(input string nm, input int g, input int lo,
		input int hi);
		compares++;
		if (g < lo || g > hi) begin
			err_count++;
			$display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask : rng

	// request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		k = 0;
		@(posedge pclk);
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 200);
		if (pready !== 1'b1) begin
			err_count++;
			$display("BAD pready exp 1 got %b", pready);
		end
		r = prdata;
		e = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rv, re);
		chk("pslverr", 32'h0, {31'h0, re});
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0, rv, re);
		chk(nm, e, rv);
	endtask : rd

	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			apb(1'b0, 12'h01C, 32'h0, rv, re);
			k++;
		end while (rv[7] !== 1'b0 && k < 20);
		chk("status_idle", 32'h0, rv);
	endtask : wait_idle

	task automatic wait_evt(input bit is_irq);
		int old;
		int k;
		old = is_irq ? irq_cyc : rst_cnt;
		k = 0;
		while ((is_irq ? irq_cyc : rst_cnt) == old && k < 3000) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 3000) begin
			err_count++;
			$display("BAD event_seen exp 1 got 0");
		end
	endtask : wait_evt

	task automatic do_reset(input wdri_cfg_t c);
		@(posedge pclk);
		presetn <= 1'b0;
		cfg <= c;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask : do_reset

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_regs();
		do_reset('{1'b0, 1'b0, 1'b0, 4'h5, 4'h3, 4'h1});
		rd(12'h004, 32'h53, "period_config");
		rd(12'h008, 32'h01, "early_warning_control");
		rd(12'h010, 32'h00, "enable_reset");
		rd(12'h018, 32'h00, "flags_reset");
		rd(12'h01C, 32'h00, "status_reset");
		rd(12'h020, 32'h00, "service_key_read");
		apb(1'b0, 12'h00C, 32'h0, rv, re);
		chk("unmapped_err", 32'h1, {31'h0, re});
		wr(12'h008, 32'hFF);
		wait_idle();
		rd(12'h008, 32'h0F, "early_warning_control_unused_zero");
	endtask : t_regs

	task automatic t_enable();
		wr(12'h014, 32'h01);
		rd(12'h010, 32'h01, "enable_via_clear");
		rd(12'h014, 32'h01, "enable_via_set");
		wr(12'h014, 32'h00);
		wr(12'h010, 32'h00);
		rd(12'h014, 32'h01, "enable_zero_writes");
		wr(12'h010, 32'h01);
		rd(12'h014, 32'h00, "enable_cleared");
	endtask : t_enable

	task automatic t_timing();
		do_reset('{1'b0, 1'b0, 1'b1, 4'h0, 4'h2, 4'h0});
		wr(12'h014, 32'h01);
		wr(12'h020, 32'hA5);
		t0 = cyc;
		wait_evt(1'b1);
		rng("warn_delay", irq_cyc - t0, 8*D-2, 9*D+4);
		wr(12'h018, 32'h00);
		rd(12'h018, 32'h01, "flag_zero_write");
		wr(12'h018, 32'h01);
		rd(12'h018, 32'h00, "flag_cleared");
		chk("irq_low", 32'h0, {31'h0, irq});
		wait_evt(1'b0);
		rng("timeout_delay", rst_cyc - t0, 32*D-2, 33*D+4);
		// just after a tick, so the sync window is still open
		wr(12'h008, 32'h03);
		rd(12'h01C, 32'h80, "status_busy");
		wait_idle();
		n = rst_cnt;
		wr(12'h020, 32'hA5);
		wr(12'h020, 32'hA5);
		chk("valid_key_quiet", n, rst_cnt);
		wr(12'h020, 32'h5A);
		repeat (2) @(posedge pclk);
		chk("wrong_key_reset", n + 1, rst_cnt);
	endtask : t_timing

	task automatic t_window();
		// offset code far beyond the window: warning must still come early
		do_reset('{1'b0, 1'b1, 1'b1, 4'h0, 4'h0, 4'h3});
		wr(12'h014, 32'h01);
		wait_evt(1'b1);
		wr(12'h018, 32'h01);
		n = rst_cnt;
		wr(12'h020, 32'hA5);
		t0 = cyc;
		wait_evt(1'b1);
		rng("open_start", irq_cyc - t0, 8*D-2, 9*D+4);
		wait_evt(1'b0);
		rng("open_end", rst_cyc - t0, 16*D-2, 17*D+4);
		chk("open_key_quiet", n + 1, rst_cnt);
		n = rst_cnt;
		wr(12'h020, 32'hA5);
		repeat (4) @(posedge pclk);
		chk("closed_key_reset", n + 1, rst_cnt);
	endtask : t_window

	task automatic t_lock();
		do_reset('{1'b1, 1'b0, 1'b1, 4'h0, 4'h3, 4'h2});
		rd(12'h000, 32'h82, "run_control_lock");
		wr(12'h000, 32'h00);
		wr(12'h004, 32'h00);
		wr(12'h008, 32'h05);
		rd(12'h000, 32'h82, "run_control_kept");
		rd(12'h004, 32'h03, "period_kept");
		rd(12'h008, 32'h02, "early_warning_control_kept");
	endtask : t_lock

	initial begin
		presetn = 1'b0;
		req = '0;
		cfg = '0;
		t_regs();
		t_enable();
		t_timing();
		t_window();
		t_lock();
		stop_test();
	end
endmodule : wdri_top_tb
